// ### rtl/dtdec_defs.vh
`ifndef DTDEC_DEFS_VH
`define DTDEC_DEFS_VH
`define DTDEC_OP_SEG_LOAD 8'h8e
`define DTDEC_OP_SEG_STORE 8'h8c
`define DTDEC_OP_FAR_DSEG 8'hc5
`define DTDEC_OP_FAR_ESEG 8'hc4
`define DTDEC_OP_TABLE 8'hd7
`define DTDEC_OP_EOFS 8'h8d
`define DTDEC_OP_FL2AH 8'h9f
`define DTDEC_OP_AH2FL 8'h9e
`define DTDEC_MOD_REG 2'h3
`define DTDEC_KIND_NONE 4'h0
`define DTDEC_KIND_SEG_LOAD 4'h1
`define DTDEC_KIND_SEG_STORE 4'h2
`define DTDEC_KIND_FAR_DSEG 4'h3
`define DTDEC_KIND_FAR_ESEG 4'h4
`define DTDEC_KIND_TABLE 4'h5
`define DTDEC_KIND_EOFS 4'h6
`define DTDEC_KIND_FL2AH 4'h7
`define DTDEC_KIND_AH2FL 4'h8
`define DTDEC_CLK_SEG_REG 6'h02
`define DTDEC_CLK_SEG_LOAD_MEM16 6'h09
`define DTDEC_CLK_SEG_LOAD_MEM8 6'h0d
`define DTDEC_CLK_SEG_STORE_MEM16 6'h0b
`define DTDEC_CLK_SEG_STORE_MEM8 6'h0f
`define DTDEC_CLK_FAR16 6'h12
`define DTDEC_CLK_FAR8 6'h1a
`define DTDEC_CLK_TABLE16 6'h0b
`define DTDEC_CLK_TABLE8 6'h0f
`define DTDEC_CLK_EOFS 6'h06
`define DTDEC_CLK_FL2AH 6'h02
`define DTDEC_CLK_AH2FL 6'h03
`define DTDEC_CLK_WORD_ADD 6'h04
`define DTDEC_CLK_MEM_SLACK 6'h02
`endif

// ### rtl/dtdec_top.v
`timescale 1ns/1ps
`include "dtdec_defs.vh"
// Contract
// RULE1: 8e with addressing byte loads segment register; 2 reg, 9 memory on 16-bit bus.
// RULE2: 8-bit bus segment load takes 2 with register, 13 with memory source.
// RULE3: 8c stores segment register; 2/11 on 16-bit bus, 2/15 on 8-bit bus.
// RULE4: c5 memory form loads far pointer to data segment; 18 or 26 clocks.
// RULE5: c4 memory form loads far pointer to extra segment, same timing.
// RULE6: d7 replaces acc low byte from table; 11 or 15 clocks.
// RULE7: 8d places effective offset in register, no memory access, 6 clocks.
// RULE8: 9f copies low flags into acc high byte, 2 clocks.
// RULE9: 9e writes acc high byte into low flags, 3 clocks.
// RULE10: 8-bit bus adds 4 clocks to marked counts for word memory moves.
// RULE11: counts are minimums; memory operations may need up to two more clocks.
// RULE12: far-pointer loads with register mode flag invalid opcode, not executed.
module dtdec_top (
   input wire clock_i,
   input wire rst_b_i,
   input wire ce_i,
   input wire valid_i,
   input wire [7:0] opcode_i,
   input wire [7:0] modrm_i,
   input wire word_i,
   input wire bus8_i,
   output wire valid_o,
   output wire [3:0] kind_o,
   output wire [1:0] seg_sel_o,
   output wire [2:0] reg_sel_o,
   output wire mem_access_o,
   output wire invalid_o,
   output wire [5:0] min_clocks_o,
   output wire [5:0] max_clocks_o
);
   wire reg_form;
   wire known_next;
   wire [5:0] base_next;
   wire [5:0] word_add;
   wire [5:0] slack_add;
   wire [6:0] min_sum;
   wire [6:0] max_sum;
   wire [5:0] min_next;
   wire [5:0] max_next;
   reg [3:0] kind_next;
   reg inv_next;
   reg mem_next;

   reg valid_reg;
   reg invalid_reg;
   reg [3:0] kind_reg;
   reg [1:0] seg_sel_reg;
   reg [2:0] reg_sel_reg;
   reg mem_access_reg;
   reg [5:0] min_clocks_reg;
   reg [5:0] max_clocks_reg;

   function [5:0] pick;
      input b8;
      input [5:0] c16;
      input [5:0] c8;
      begin
         pick = b8 ? c8 : c16;
      end
   endfunction

   // figure with a memory operand; the narrow bus part has its own column
   function [5:0] mem_figure;
      input [3:0] kind;
      input b8;
      begin
         case (kind)
            `DTDEC_KIND_SEG_LOAD: begin
               mem_figure = pick(b8, `DTDEC_CLK_SEG_LOAD_MEM16, `DTDEC_CLK_SEG_LOAD_MEM8); // [RULE1] [RULE2]
            end
            `DTDEC_KIND_SEG_STORE: begin
               mem_figure = pick(b8, `DTDEC_CLK_SEG_STORE_MEM16, `DTDEC_CLK_SEG_STORE_MEM8); // [RULE3]
            end
            `DTDEC_KIND_FAR_DSEG, `DTDEC_KIND_FAR_ESEG: begin
               mem_figure = pick(b8, `DTDEC_CLK_FAR16, `DTDEC_CLK_FAR8); // [RULE4] [RULE5]
            end
            `DTDEC_KIND_TABLE: begin
               mem_figure = pick(b8, `DTDEC_CLK_TABLE16, `DTDEC_CLK_TABLE8); // [RULE6]
            end
            default: begin
               mem_figure = 6'h00;
            end
         endcase
      end
   endfunction

   // figure without a memory operand; same on both bus variants
   function [5:0] reg_figure;
      input [3:0] kind;
      begin
         case (kind)
            `DTDEC_KIND_SEG_LOAD, `DTDEC_KIND_SEG_STORE: begin
               reg_figure = `DTDEC_CLK_SEG_REG; // [RULE1] [RULE2] [RULE3]
            end
            `DTDEC_KIND_EOFS: begin
               reg_figure = `DTDEC_CLK_EOFS; // [RULE7]
            end
            `DTDEC_KIND_FL2AH: begin
               reg_figure = `DTDEC_CLK_FL2AH; // [RULE8]
            end
            `DTDEC_KIND_AH2FL: begin
               reg_figure = `DTDEC_CLK_AH2FL; // [RULE9]
            end
            default: begin
               reg_figure = 6'h00;
            end
         endcase
      end
   endfunction

   // offset load only computes the address, so it never counts as a memory operation
   function uses_memory;
      input [3:0] kind;
      input reg_mode;
      begin
         case (kind)
            `DTDEC_KIND_SEG_LOAD, `DTDEC_KIND_SEG_STORE: begin
               uses_memory = ~reg_mode;
            end
            `DTDEC_KIND_FAR_DSEG, `DTDEC_KIND_FAR_ESEG, `DTDEC_KIND_TABLE: begin
               uses_memory = 1'b1;
            end
            default: begin
               uses_memory = 1'b0; // [RULE7]
            end
         endcase
      end
   endfunction

   // no decoded row carries the byte-transfer mark; a marked row would return one here
   function byte_marked;
      input [3:0] kind;
      begin
         byte_marked = 1'b0;
      end
   endfunction

   assign reg_form = (modrm_i[7:6] == `DTDEC_MOD_REG);

   always @* begin
      kind_next = `DTDEC_KIND_NONE;
      inv_next = 1'b0;
      case (opcode_i)
         `DTDEC_OP_SEG_LOAD: begin
            kind_next = `DTDEC_KIND_SEG_LOAD; // [RULE1]
         end
         `DTDEC_OP_SEG_STORE: begin
            kind_next = `DTDEC_KIND_SEG_STORE; // [RULE3]
         end
         `DTDEC_OP_FAR_DSEG: begin
            if (reg_form) begin
               inv_next = 1'b1; // [RULE12]
            end else begin
               kind_next = `DTDEC_KIND_FAR_DSEG; // [RULE4]
            end
         end
         `DTDEC_OP_FAR_ESEG: begin
            if (reg_form) begin
               inv_next = 1'b1; // [RULE12]
            end else begin
               kind_next = `DTDEC_KIND_FAR_ESEG; // [RULE5]
            end
         end
         `DTDEC_OP_TABLE: begin
            kind_next = `DTDEC_KIND_TABLE; // [RULE6]
         end
         `DTDEC_OP_EOFS: begin
            kind_next = `DTDEC_KIND_EOFS; // [RULE7]
         end
         `DTDEC_OP_FL2AH: begin
            kind_next = `DTDEC_KIND_FL2AH; // [RULE8]
         end
         `DTDEC_OP_AH2FL: begin
            kind_next = `DTDEC_KIND_AH2FL; // [RULE9]
         end
         default: begin
            kind_next = `DTDEC_KIND_NONE;
         end
      endcase
      mem_next = uses_memory(kind_next, reg_form);
   end

   assign known_next = (kind_next != `DTDEC_KIND_NONE);
   assign base_next = mem_next ? mem_figure(kind_next, bus8_i) : reg_figure(kind_next);
   // the narrow bus pays extra only for word moves through memory on marked rows
   assign word_add = (byte_marked(kind_next) & bus8_i & word_i & mem_next) ?
      `DTDEC_CLK_WORD_ADD : 6'h00; // [RULE10]
   // figures are minimums; a memory operation may cost up to two more
   assign slack_add = mem_next ? `DTDEC_CLK_MEM_SLACK : 6'h00; // [RULE11]
   assign min_sum = {1'b0, base_next} + {1'b0, word_add};
   assign max_sum = min_sum + {1'b0, slack_add};
   // the largest sum stays well under 64, so dropping the carry bit loses nothing
   assign min_next = min_sum[5:0];
   assign max_next = max_sum[5:0];

   // answer flags last one clock-enabled cycle per taken request and hold while ce_i is low
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         valid_reg <= 1'b0;
         invalid_reg <= 1'b0;
      end else if (ce_i) begin
         valid_reg <= valid_i & known_next;
         invalid_reg <= valid_i & inv_next; // [RULE12]
      end
   end

   // decoded fields stand until the next taken request
   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         kind_reg <= `DTDEC_KIND_NONE;
         seg_sel_reg <= 2'h0;
         reg_sel_reg <= 3'h0;
         mem_access_reg <= 1'b0;
      end else if (ce_i & valid_i) begin
         kind_reg <= kind_next;
         seg_sel_reg <= modrm_i[4:3]; // [RULE1] [RULE3]
         reg_sel_reg <= modrm_i[5:3];
         mem_access_reg <= mem_next;
      end
   end

   always @(posedge clock_i) begin
      if (!rst_b_i) begin
         min_clocks_reg <= 6'h00;
         max_clocks_reg <= 6'h00;
      end else if (ce_i & valid_i) begin
         min_clocks_reg <= min_next;
         max_clocks_reg <= max_next; // [RULE11]
      end
   end

   assign valid_o = valid_reg;
   assign invalid_o = invalid_reg;
   assign kind_o = kind_reg;
   assign seg_sel_o = seg_sel_reg;
   assign reg_sel_o = reg_sel_reg;
   assign mem_access_o = mem_access_reg;
   assign min_clocks_o = min_clocks_reg;
   assign max_clocks_o = max_clocks_reg;
endmodule

// ### tb/dtdec_asserts.sv
`timescale 1ns/1ps
module dtdec_chk (input wire clock_i, rst_b_i, ce_i, valid_i, word_i, bus8_i, valid_o, mem_access_o, invalid_o,
   input wire [7:0] opcode_i, modrm_i, input wire [3:0] kind_o, input wire [1:0] seg_sel_o,
   input wire [2:0] reg_sel_o, input wire [5:0] min_clocks_o, max_clocks_o);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   wire t = ce_i & valid_i;
   wire mm = modrm_i[7:6] != 2'h3;
   a_seg_load16: assert property (t && opcode_i == 8'h8e && !bus8_i |=> valid_o && kind_o == 4'h1 &&
      min_clocks_o == ($past(mm) ? 6'h09 : 6'h02)) else $error("seg load 16");
   a_seg_load8: assert property (t && opcode_i == 8'h8e && bus8_i && mm |=> min_clocks_o == 6'h0d)
      else $error("seg load 8");
   a_seg_store: assert property (t && opcode_i == 8'h8c && mm |=> kind_o == 4'h2 &&
      min_clocks_o == ($past(bus8_i) ? 6'h0f : 6'h0b)) else $error("seg store");
   a_far_load: assert property (t && opcode_i[7:1] == 7'h62 && mm |=> valid_o && mem_access_o &&
      min_clocks_o == ($past(bus8_i) ? 6'h1a : 6'h12)) else $error("far load");
   a_far_reg_bad: assert property (t && opcode_i[7:1] == 7'h62 && !mm |=> invalid_o && !valid_o &&
      kind_o == 4'h0) else $error("far load reg form");
   a_table_clocks: assert property (t && opcode_i == 8'hd7 |=> kind_o == 4'h5 &&
      min_clocks_o == ($past(bus8_i) ? 6'h0f : 6'h0b)) else $error("table lookup");
   a_eofs_clocks: assert property (t && opcode_i == 8'h8d |=> kind_o == 4'h6 && !mem_access_o &&
      min_clocks_o == 6'h06 && max_clocks_o == 6'h06) else $error("offset load");
   a_flag_clocks: assert property (t && opcode_i[7:1] == 7'h4f |=> max_clocks_o == min_clocks_o &&
      min_clocks_o == (($past(opcode_i) == 8'h9f) ? 6'h02 : 6'h03)) else $error("flag moves");
   a_mem_slack: assert property (valid_o && mem_access_o |-> max_clocks_o == min_clocks_o + 6'h02)
      else $error("memory slack");
   a_seg_fields: assert property (t && opcode_i[7:2] == 6'h23 && !opcode_i[0] |=>
      seg_sel_o == $past(modrm_i[4:3]) && reg_sel_o == $past(modrm_i[5:3])) else $error("segment fields");
   a_ce_freeze: assert property (!ce_i |=> $stable(valid_o) && $stable(invalid_o) && $stable(kind_o) &&
      $stable(min_clocks_o) && $stable(max_clocks_o)) else $error("clock enable freeze");
endmodule
bind dtdec_top dtdec_chk i_chk (.*);

// ### tb/data_transfer_decoder_tb.sv
`timescale 1ns/1ps
module data_transfer_decoder_tb;
   reg clock_i = 0, rst_b_i = 0, ce_i = 1, valid_i = 0, word_i = 0, bus8_i = 0;
   reg [7:0] opcode_i = 8'h00, modrm_i = 8'h00;
   wire valid_o, mem_access_o, invalid_o;
   wire [3:0] kind_o;
   wire [1:0] seg_sel_o;
   wire [2:0] reg_sel_o;
   wire [5:0] min_clocks_o, max_clocks_o;
   integer error_cnt = 0, num_checks = 0;
   dtdec_top i_dut (.*);
   always #5 clock_i = ~clock_i;
   task cmp(input string what, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // k holds valid, invalid, kind; word set on the 8-bit bus shows no byte-transfer add
   task run(input [7:0] op, m, input b8, input [5:0] k, mn, mx);
      @(negedge clock_i);
      {valid_i, opcode_i, modrm_i, bus8_i, word_i} = {1'b1, op, m, b8, b8};
      @(negedge clock_i);
      valid_i = 0;
      cmp("decode", {valid_o, invalid_o, kind_o}, k);
      if (!k[4]) cmp("clocks", {min_clocks_o, max_clocks_o}, {mn, mx});
      if (k[5]) cmp("fields", {mem_access_o, seg_sel_o, reg_sel_o}, {mx != mn, m[4:3], m[5:3]});
   endtask
   task s_seg;
      run(8'h8e, 8'hc0, 0, 6'h21, 2, 2);
      run(8'h8e, 8'h06, 0, 6'h21, 9, 11);
      run(8'h8e, 8'h46, 1, 6'h21, 13, 15);
      run(8'h8c, 8'hd8, 1, 6'h22, 2, 2);
      run(8'h8c, 8'h9e, 0, 6'h22, 11, 13);
      run(8'h8c, 8'h1e, 1, 6'h22, 15, 17);
   endtask
   task s_far;
      run(8'hc5, 8'h06, 0, 6'h23, 18, 20);
      run(8'hc4, 8'h46, 1, 6'h24, 26, 28);
      run(8'hc5, 8'hc0, 0, 6'h10, 0, 0);
      run(8'hc4, 8'hd1, 1, 6'h10, 0, 0);
   endtask
   task s_misc;
      run(8'hd7, 8'h00, 0, 6'h25, 11, 13);
      run(8'hd7, 8'h00, 1, 6'h25, 15, 17);
      run(8'h8d, 8'h86, 1, 6'h26, 6, 6);
      run(8'h9f, 8'h00, 1, 6'h27, 2, 2);
      run(8'h9e, 8'h00, 0, 6'h28, 3, 3);
      run(8'h90, 8'h00, 0, 6'h00, 0, 0);
   endtask
   // clock enable low must freeze every output, even the one-cycle valid flag
   task s_hold;
      run(8'h8c, 8'h1e, 1, 6'h22, 15, 17);
      {ce_i, opcode_i, bus8_i} = {1'b0, 8'hd7, 1'b0};
      @(negedge clock_i);
      valid_i = 1;
      @(negedge clock_i);
      cmp("freeze", {valid_o, kind_o, min_clocks_o}, {1'b1, 4'h2, 6'h0f});
      ce_i = 1;
      @(negedge clock_i);
      valid_i = 0;
      cmp("resume", {valid_o, kind_o, min_clocks_o}, {1'b1, 4'h5, 6'h0b});
   endtask
   task s_reset;
      run(8'hc5, 8'h06, 0, 6'h23, 18, 20);
      rst_b_i = 0;
      @(negedge clock_i);
      rst_b_i = 1;
      cmp("reset", {valid_o, invalid_o, kind_o, mem_access_o, seg_sel_o, reg_sel_o,
         min_clocks_o, max_clocks_o}, 0);
      run(8'h8e, 8'h46, 1, 6'h21, 13, 15);
   endtask
   // requests on two cycles in a row
   task s_burst;
      @(negedge clock_i);
      {valid_i, opcode_i, modrm_i, bus8_i} = {1'b1, 8'h9f, 8'h00, 1'b0};
      @(negedge clock_i);
      opcode_i = 8'h9e;
      cmp("first", {valid_o, kind_o, min_clocks_o}, {1'b1, 4'h7, 6'h02});
      @(negedge clock_i);
      valid_i = 0;
      cmp("second", {valid_o, kind_o, min_clocks_o}, {1'b1, 4'h8, 6'h03});
   endtask
   task wrap_up;
      if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (16) @(negedge clock_i);
      rst_b_i = 1;
      s_seg;
      s_far;
      s_misc;
      s_hold;
      s_reset;
      s_burst;
      wrap_up;
   end
endmodule
